/* board_strap_model.sv */
// Board model for the ROM size straps seen by the overlay decoder.
// Assumes a size is picked only while no memory request depends on it.

`timescale 1ns/1ps

// ============================================================
// Strap model
// ============================================================
module board_strap_model (
    // Size fitted on the board.
    input boot_rom_overlay_pkg::rom_size_t size_sel,
    // Strap levels, at most one high since only one jumper fits.
    output logic rom_size_strap_large,
    output logic rom_size_strap_medium
);
    // The small size is the absence of any strap.
    assign rom_size_strap_large = (size_sel == boot_rom_overlay_pkg::SIZE_LARGE);
    assign rom_size_strap_medium = (size_sel == boot_rom_overlay_pkg::SIZE_MEDIUM);
endmodule : board_strap_model

/* boot_rom_overlay_decode.sv */
// Memory decode for a boot ROM overlaying the low 32 Kbyte of a 64 Kbyte map.
// Assumes the processor holds mem_addr steady while mem_req is high and that
// chip selects may lag the request by one sys_clk cycle.

`timescale 1ns/1ps

// ============================================================
// Top module
// ============================================================
// Notes on behaviour
// - After reset the boot ROM of at least 32 Kbit answers from address zero upward.
// - The ROM enable comes out of reset set, so ROM serves the low half up to the fitted ROM's top address.
// - In the low half, ROM, RAM or neither is selected for an access, never both.
// - A software write to the overlay control bit enables or disables the ROM overlay.
// - The upper half of the map always selects RAM.
// - The decode handles a ROM of up to 128 Kbit, filling the first 16 Kbyte.
module boot_rom_overlay_decode (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rstn,
    // Processor memory request.
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    // Overlay control register write port.
    input wire logic overlay_ctrl_wr,
    input wire logic overlay_ctrl_rom_en,
    // Size straps.
    input wire logic rom_size_strap_large,
    input wire logic rom_size_strap_medium,
    // Chip selects and ROM address.
    output logic rom_cs_q,
    output logic ram_cs_q,
    output logic [13:0] rom_addr_q,
    output logic rom_en_q
);
    boot_rom_overlay_pkg::rom_size_t rom_size;
    logic [15:0] rom_top;
    logic low_half;
    logic in_rom;
    logic rom_cs_d;
    logic ram_cs_d;
    logic [13:0] rom_addr_d;

    // True when the address lies in the shared low half.
    function automatic logic is_low_half(input logic [15:0] a);
        return a[boot_rom_overlay_pkg::HALF_BIT] == 1'b0;
    endfunction : is_low_half

    // Masks ROM address lines above the fitted device to zero.
    function automatic logic [13:0] mask_rom_addr(input logic [15:0] a,
                                                  input boot_rom_overlay_pkg::rom_size_t s);
        logic [13:0] m;
        m = a[13:0];
        case (s)
            boot_rom_overlay_pkg::SIZE_SMALL: m[13:12] = 2'h0;
            boot_rom_overlay_pkg::SIZE_MEDIUM: m[13] = 1'b0;
            boot_rom_overlay_pkg::SIZE_LARGE: m = a[13:0];
            default: m[13:12] = 2'h0;
        endcase
        return m;
    endfunction : mask_rom_addr

    // ========================================================
    // Strap decode
    // ========================================================
    rom_size_decode u_size (
        .rom_size_strap_large(rom_size_strap_large),
        .rom_size_strap_medium(rom_size_strap_medium),
        .rom_size(rom_size),
        .rom_top(rom_top)
    );

    // ========================================================
    // Overlay control bit
    // ========================================================
    // Reset forces the overlay on so the boot program is found at zero.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rom_en_q <= boot_rom_overlay_pkg::ROM_EN_RESET;
        end else if (overlay_ctrl_wr) begin
            rom_en_q <= overlay_ctrl_rom_en;
        end
    end

    // ========================================================
    // Address decode
    // ========================================================
    // Addresses above the fitted ROM but still in the low half select
    // nothing while the overlay is on; aliasing the ROM there would hide the
    // missing RAM less honestly than an open read.
    always_comb begin
        low_half = is_low_half(mem_addr);
        in_rom = low_half && (mem_addr <= rom_top);
        rom_cs_d = mem_req && rom_en_q && in_rom;
        ram_cs_d = mem_req && !(rom_en_q && low_half);
        rom_addr_d = mask_rom_addr(mem_addr, rom_size);
    end

    // Registered selects; one cycle of latency keeps the outputs glitch free.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rom_cs_q <= boot_rom_overlay_pkg::SEL_RESET;
            ram_cs_q <= boot_rom_overlay_pkg::SEL_RESET;
            rom_addr_q <= boot_rom_overlay_pkg::ROM_ADDR_RESET;
        end else begin
            rom_cs_q <= rom_cs_d;
            ram_cs_q <= ram_cs_d;
            rom_addr_q <= rom_addr_d;
        end
    end

    // ========================================================
    // Assertions
    // ========================================================
    property p_boot_at_zero;
        @(posedge sys_clk) disable iff (!rstn)
        $rose(rstn) ##0 mem_req && mem_addr == 16'h0000 |=> rom_cs_q && !ram_cs_q;
    endproperty
    a_boot_at_zero: assert property (p_boot_at_zero)
        else $error("ROM not selected at address zero after reset.");

    property p_reset_rom_en;
        @(posedge sys_clk) !rstn |=> rom_en_q;
    endproperty
    a_reset_rom_en: assert property (p_reset_rom_en)
        else $error("ROM enable not set after reset.");

    property p_exclusive;
        @(posedge sys_clk) disable iff (!rstn) !(rom_cs_q && ram_cs_q);
    endproperty
    a_exclusive: assert property (p_exclusive)
        else $error("ROM and RAM selected together.");

    property p_ctrl_write;
        @(posedge sys_clk) disable iff (!rstn)
        overlay_ctrl_wr ##1 (mem_req && mem_addr == 16'h0000 && !overlay_ctrl_wr)
            |=> (rom_cs_q == $past(overlay_ctrl_rom_en, 2)) && (ram_cs_q != rom_cs_q);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("Overlay control write did not steer the low half.");

    property p_upper_ram;
        @(posedge sys_clk) disable iff (!rstn)
        mem_req && mem_addr[15] |=> ram_cs_q && !rom_cs_q;
    endproperty
    a_upper_ram: assert property (p_upper_ram)
        else $error("Upper half access did not select RAM.");

    property p_large_top;
        @(posedge sys_clk) disable iff (!rstn)
        mem_req && rom_en_q && rom_size_strap_large && mem_addr == 16'h3FFF
            |=> rom_cs_q && rom_addr_q == 14'h3FFF;
    endproperty
    a_large_top: assert property (p_large_top)
        else $error("Top of 128 Kbit ROM not selected.");

    property p_small_size;
        @(posedge sys_clk) disable iff (!rstn)
        mem_req && rom_en_q && !rom_size_strap_large && !rom_size_strap_medium
            && mem_addr == 16'h1000 |=> !rom_cs_q && !ram_cs_q;
    endproperty
    a_small_size: assert property (p_small_size)
        else $error("Unstrapped ROM answered above 32 Kbit.");

    property p_medium_addr;
        @(posedge sys_clk) disable iff (!rstn)
        rom_size_strap_medium && !rom_size_strap_large |=> rom_addr_q[13] == 1'b0;
    endproperty
    a_medium_addr: assert property (p_medium_addr)
        else $error("ROM line 13 driven for a 64 Kbit device.");

    // RAM must stay off anywhere in the low half while the overlay is on.
    property p_ram_off_low;
        @(posedge sys_clk) disable iff (!rstn)
        mem_req && rom_en_q && !mem_addr[boot_rom_overlay_pkg::HALF_BIT] |=> !ram_cs_q;
    endproperty
    a_ram_off_low: assert property (p_ram_off_low)
        else $error("RAM selected in the low half with ROM enabled.");

    // With the overlay off every request lands in RAM alone.
    property p_overlay_off_ram;
        @(posedge sys_clk) disable iff (!rstn)
        mem_req && !rom_en_q |=> ram_cs_q && !rom_cs_q;
    endproperty
    a_overlay_off_ram: assert property (p_overlay_off_ram)
        else $error("Request with the overlay off did not select RAM alone.");

    // Without a request both selects are low one edge later.
    property p_idle_no_select;
        @(posedge sys_clk) disable iff (!rstn)
        !mem_req |=> !rom_cs_q && !ram_cs_q;
    endproperty
    a_idle_no_select: assert property (p_idle_no_select)
        else $error("A select was raised without a request.");

    // The control bit keeps its value between writes.
    property p_en_hold;
        @(posedge sys_clk) disable iff (!rstn)
        !overlay_ctrl_wr |=> $stable(rom_en_q);
    endproperty
    a_en_hold: assert property (p_en_hold)
        else $error("Overlay enable changed without a write.");

    // The largest device sees every low address line unmasked.
    property p_large_addr;
        @(posedge sys_clk) disable iff (!rstn)
        rom_size_strap_large |=> rom_addr_q == $past(mem_addr[13:0]);
    endproperty
    a_large_addr: assert property (p_large_addr)
        else $error("ROM lines do not follow the address for a 128 Kbit device.");

    // An unstrapped device keeps the two top ROM lines low.
    property p_small_addr;
        @(posedge sys_clk) disable iff (!rstn)
        !rom_size_strap_large && !rom_size_strap_medium |=> rom_addr_q[13:12] == 2'h0;
    endproperty
    a_small_addr: assert property (p_small_addr)
        else $error("Top ROM lines driven for a 32 Kbit device.");

    // Just above a 64 Kbit device neither select answers while ROM is on.
    property p_medium_top;
        @(posedge sys_clk) disable iff (!rstn)
        mem_req && rom_en_q && rom_size_strap_medium && !rom_size_strap_large
            && mem_addr == 16'h2000 |=> !rom_cs_q && !ram_cs_q;
    endproperty
    a_medium_top: assert property (p_medium_top)
        else $error("A 64 Kbit device answered above its top.");
endmodule : boot_rom_overlay_decode

/* boot_rom_overlay_pkg.sv */
// Constants for the boot ROM overlay decode, and the strap-to-size decoder.
// Assumes straps are static board levels, synchronous to sys_clk.

`timescale 1ns/1ps

// ============================================================
// Shared constants
// ============================================================
package boot_rom_overlay_pkg;
    localparam int ADDR_W = 16;
    localparam int ROM_ADDR_W = 14;
    // Address bit that splits the shared low half from the upper RAM half.
    localparam int HALF_BIT = 15;
    // Top address of each fitted ROM size (32, 64, 128 Kbit).
    localparam logic [15:0] ROM_TOP_SMALL = 16'h0FFF;
    localparam logic [15:0] ROM_TOP_MEDIUM = 16'h1FFF;
    localparam logic [15:0] ROM_TOP_LARGE = 16'h3FFF;
    // The overlay comes out of reset enabled.
    localparam logic ROM_EN_RESET = 1'b1;
    // Selects are idle and the ROM lines low while reset is held.
    localparam logic SEL_RESET = 1'b0;
    localparam logic [13:0] ROM_ADDR_RESET = 14'h0000;

    typedef enum logic [1:0] {
        SIZE_SMALL = 2'b00,
        SIZE_MEDIUM = 2'b01,
        SIZE_LARGE = 2'b10
    } rom_size_t;
endpackage : boot_rom_overlay_pkg

// ============================================================
// Strap decoder
// ============================================================
module rom_size_decode (
    // Board straps, high when the common point is joined to the option.
    input wire logic rom_size_strap_large,
    input wire logic rom_size_strap_medium,
    // Decoded size and the top ROM address for it.
    output boot_rom_overlay_pkg::rom_size_t rom_size,
    output logic [15:0] rom_top
);
    // Only one strap may be fitted; should both be, the larger size wins so
    // that no part of a fitted device becomes unreachable.
    always_comb begin
        if (rom_size_strap_large) begin
            rom_size = boot_rom_overlay_pkg::SIZE_LARGE;
            rom_top = boot_rom_overlay_pkg::ROM_TOP_LARGE;
        end else if (rom_size_strap_medium) begin
            rom_size = boot_rom_overlay_pkg::SIZE_MEDIUM;
            rom_top = boot_rom_overlay_pkg::ROM_TOP_MEDIUM;
        end else begin
            rom_size = boot_rom_overlay_pkg::SIZE_SMALL;
            rom_top = boot_rom_overlay_pkg::ROM_TOP_SMALL;
        end
    end
endmodule : rom_size_decode

/* tb_boot_rom_overlay_decode.sv */
// Self-checking bench for the boot ROM overlay decoder.
// Assumes selects follow a request by exactly one sys_clk edge.

`timescale 1ns/1ps

// ============================================================
// Bench top
// ============================================================
module tb_boot_rom_overlay_decode;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic mem_req = 1'b0;
    logic [15:0] mem_addr = 16'h0000;
    logic overlay_ctrl_wr = 1'b0;
    logic overlay_ctrl_rom_en = 1'b0;
    boot_rom_overlay_pkg::rom_size_t size_sel = boot_rom_overlay_pkg::SIZE_SMALL;
    logic strap_large, strap_medium, rom_cs_q, ram_cs_q, rom_en_q;
    logic [13:0] rom_addr_q;
    logic exp_en = 1'b1;
    logic [15:0] exp_top = 16'h0FFF;
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;

    // Clock at 125 MHz.
    always #4 sys_clk = ~sys_clk;

    board_strap_model u_straps (.size_sel(size_sel), .rom_size_strap_large(strap_large),
        .rom_size_strap_medium(strap_medium));
    boot_rom_overlay_decode u_dut (.sys_clk(sys_clk), .rstn(rstn), .mem_req(mem_req),
        .mem_addr(mem_addr), .overlay_ctrl_wr(overlay_ctrl_wr),
        .overlay_ctrl_rom_en(overlay_ctrl_rom_en), .rom_size_strap_large(strap_large),
        .rom_size_strap_medium(strap_medium), .rom_cs_q(rom_cs_q), .ram_cs_q(ram_cs_q),
        .rom_addr_q(rom_addr_q), .rom_en_q(rom_en_q));

    // The single place where the run ends, from the timeout or the main sequence.
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d.", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    // A hang is cut short well beyond the roughly fifty cycles the tests need.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            print_verdict();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // One request; expectation is worked out from overlay state and fitted size.
    task automatic access(input logic req, input logic [15:0] addr);
        logic exp_rom;
        logic exp_ram;
        exp_rom = req && exp_en && !addr[15] && (addr <= exp_top);
        exp_ram = req && (addr[15] || !exp_en);
        mem_req = req;
        mem_addr = addr;
        @(posedge sys_clk);
        #1;
        check({15'h0000, rom_cs_q}, {15'h0000, exp_rom}, "rom select");
        check({15'h0000, ram_cs_q}, {15'h0000, exp_ram}, "ram select");
        check({2'h0, rom_addr_q}, addr & exp_top & 16'h3FFF, "rom address");
    endtask : access

    // One control write; hold keeps the strobe up when another write follows at once,
    // so the strobe is never lowered and raised again in one time step.
    task automatic ctrl_write(input logic en, input logic hold);
        overlay_ctrl_wr = 1'b1;
        overlay_ctrl_rom_en = en;
        @(posedge sys_clk);
        #1;
        if (!hold) begin
            overlay_ctrl_wr = 1'b0;
        end
        exp_en = en;
    endtask : ctrl_write

    // Walks each size across every size top, the half boundary and an idle cycle.
    task automatic test_sizes();
        logic [15:0] tops [3] = '{boot_rom_overlay_pkg::ROM_TOP_SMALL,
            boot_rom_overlay_pkg::ROM_TOP_MEDIUM, boot_rom_overlay_pkg::ROM_TOP_LARGE};
        for (int i = 0; i < 3; i++) begin
            size_sel = boot_rom_overlay_pkg::rom_size_t'(i);
            exp_top = tops[i];
            repeat (2) @(posedge sys_clk);
            #1;
            foreach (tops[j]) access(1'b1, tops[j] + 16'h0001);
            access(1'b1, exp_top);
            access(1'b1, 16'h7FFF);
            access(1'b1, 16'h8000);
            access(1'b0, 16'h0123);
        end
        $display("Size test done.");
    endtask : test_sizes

    // Overlay off, writes back to back, then a reset in mid-run while off.
    task automatic test_overlay();
        ctrl_write(1'b0, 1'b0);
        check({15'h0000, rom_en_q}, 16'h0000, "enable off");
        access(1'b1, 16'h0000);
        access(1'b1, 16'h4000);
        access(1'b1, 16'hFFFF);
        ctrl_write(1'b1, 1'b1);
        check({15'h0000, rom_en_q}, 16'h0001, "enable on");
        ctrl_write(1'b0, 1'b1);
        check({15'h0000, rom_en_q}, 16'h0000, "enable off again");
        ctrl_write(1'b1, 1'b0);
        check({15'h0000, rom_en_q}, 16'h0001, "enable back on");
        access(1'b1, 16'h0000);
        ctrl_write(1'b0, 1'b0);
        rstn = 1'b0;
        exp_en = 1'b1;
        @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        check({15'h0000, rom_en_q}, 16'h0001, "enable after reset");
        check({14'h0000, rom_cs_q, ram_cs_q}, 16'h0000, "selects after reset");
        access(1'b1, 16'h0000);
        $display("Overlay test done.");
    endtask : test_overlay

    // Reset state, then the first fetches from the bottom of the boot ROM.
    task automatic test_boot();
        check({15'h0000, rom_en_q}, 16'h0001, "enable in reset");
        check({14'h0000, rom_cs_q, ram_cs_q}, 16'h0000, "selects in reset");
        rstn = 1'b1;
        access(1'b1, 16'h0000);
        access(1'b1, boot_rom_overlay_pkg::ROM_TOP_SMALL);
        $display("Boot test done.");
    endtask : test_boot

    // Reset is held for ten edges, then the scenarios run in turn.
    initial begin
        repeat (10) @(posedge sys_clk);
        #1;
        test_boot();
        test_sizes();
        test_overlay();
        print_verdict();
    end
endmodule : tb_boot_rom_overlay_decode
